// >>> hdl/ext_bus_defines.vh
`ifndef EXT_BUS_DEFINES_VH
`define EXT_BUS_DEFINES_VH

// strobe window phases inside one half machine cycle (six windows)
`define PH_LAST 3'h5
`define ALE_LAST_PH 3'h1
`define ADDR_LAST_PH 3'h2
`define STB_FIRST_PH 3'h3
`define CAP_PH 3'h2

// half-cycle kinds, one-hot
`define K_IDLE 4'h1
`define K_FETCH 4'h2
`define K_DATA_A 4'h4
`define K_DATA_B 4'h8

// reset pin hold time, in machine cycles of twelve oscillator clocks
`define RST_HOLD_MC 2
`define OSC_PER_MC 12
`define RST_CNT_W 5

// cycles after reset before the access strap is trusted
`define SEL_SETTLE 3'h5

// top of internal code space
`define INT_CODE_TOP 16'h1fff

// reset values
`define PORT_RST 8'hff
`define SYNC_RST 10'h1ff

`endif

// >>> hdl/ext_mem_bus.v
`timescale 1ns/1ps
`include "ext_bus_defines.vh"

// Operation
// R1 - low address byte and data share the low port in turn
// R2 - low port drives both levels while it serves as bus
// R3 - high port carries upper address on fetches and wide-pointer data accesses
// R4 - high port drives address ones strongly
// R5 - indirect data accesses leave high port showing its own latch
// R6 - low port bit written one floats as an input
// R7 - other ports written one stay weakly pulled high
// R8 - address latch strobe lets an outside latch catch the low byte
// R9 - address latch strobe pulses at one sixth of the clock
// R10 - one address latch pulse dropped per data access
// R11 - disable bit limits latch strobe to move instructions, else weak high
// R12 - disable bit ignored while executing external code; code ignores it only with select low, not above internal code top
// R13 - program read strobe enables external code memory
// R14 - program read strobe twice per machine cycle in external execution
// R15 - two program read strobes dropped per data access
// R16 - select held low fetches every code address externally
// R17 - select held high runs code internally
// R18 - with lock bit one, select caught at reset and kept
// R19 - data write strobe on port three bit six, read on bit seven
// R20 - reset pin high two machine cycles resets the device
// R21 - low address valid before latch strobe falls, then data or float
// R22 - read and write strobes active low, one window per access
module ext_mem_bus (
   // clock and reset
   input wire core_clk,
   input wire rst_n,
   // reset pin, access select strap and lock fuse
   input wire resetPin,
   input wire extAccessSelN,
   input wire lockBit1,
   output wire coreReset,
   // code fetch request from the core
   input wire fetchReq,
   input wire [15:0] fetchAddr,
   output wire [7:0] fetchData,
   output wire fetchDone,
   // external data request from the core
   input wire xdataReq,
   input wire xdataWrite,
   input wire xdataWide,
   input wire [15:0] xdataAddr,
   input wire [7:0] xdataWrData,
   output wire [7:0] xdataRdData,
   output wire xdataDone,
   // latch strobe control
   input wire aleDisable,
   input wire codeMoveActive,
   // port latches held by the core
   input wire [7:0] lowPortLatch,
   input wire [7:0] highPortLatch,
   input wire [7:0] aux1Latch,
   input wire [7:0] aux3Latch,
   // low address/data port pins
   input wire [7:0] lowPortIn,
   output wire [7:0] lowPortOut,
   output wire [7:0] lowPortOe,
   output wire [7:0] lowPortValue,
   // high address port pins
   output wire [7:0] highPortOut,
   output wire [7:0] highPortOe,
   output wire [7:0] highPortWeak,
   // port one pins
   output wire [7:0] aux1Out,
   output wire [7:0] aux1Oe,
   output wire [7:0] aux1Weak,
   // port three pins, data strobes on bits six and seven
   output wire [7:0] aux3Out,
   output wire [7:0] aux3Oe,
   output wire [7:0] aux3Weak,
   // address latch strobe and program read strobe pins
   output wire aleOut,
   output wire aleOe,
   output wire aleWeak,
   output wire prgReadStrobeN
);

   localparam [`RST_CNT_W-1:0] RST_CYC = `RST_HOLD_MC * `OSC_PER_MC;

   // quasi-bidirectional drive: only zeros are driven hard
   function [7:0] quasiOe;
      input [7:0] val;
      begin
         quasiOe = ~val;
      end
   endfunction

   // a bit moves only once stages two and three agree
   function [9:0] agree;
      input [9:0] s2;
      input [9:0] s3;
      input [9:0] old;
      begin
         agree = (s2 & ~(s2 ^ s3)) | (old & (s2 ^ s3));
      end
   endfunction

   reg [9:0] syncS1_r;
   reg [9:0] syncS2_r;
   reg [9:0] syncS3_r;
   reg [9:0] syncFilt_r;
   reg [`RST_CNT_W-1:0] rstCnt_r;
   reg devRst_r;
   reg [2:0] settle_r;
   reg selLatched_r;
   reg [2:0] ph_r;
   reg [2:0] ph_nxt;
   reg halfB_r;
   reg halfB_nxt;
   reg [3:0] kind_r;
   reg [3:0] kind_nxt;
   reg wr_r;
   reg wr_nxt;
   reg wide_r;
   reg wide_nxt;
   reg [15:0] addr_r;
   reg [15:0] addr_nxt;
   reg [7:0] wdat_r;
   reg [7:0] wdat_nxt;
   reg fReq_r;
   reg fReq_nxt;
   reg fPend_r;
   reg dPend_r;
   reg [7:0] fData_r;
   reg fDone_r;
   reg [7:0] dData_r;
   reg dDone_r;
   reg [7:0] lpOut_r;
   reg [7:0] lpOut_nxt;
   reg [7:0] lpOe_r;
   reg [7:0] lpOe_nxt;
   reg [7:0] hpOut_r;
   reg [7:0] hpOut_nxt;
   reg [7:0] hpOe_r;
   reg [7:0] hpOe_nxt;
   reg [7:0] hpWeak_r;
   reg [7:0] hpWeak_nxt;
   reg [7:0] a1Out_r;
   reg [7:0] a3Out_r;
   reg [7:0] a3Out_nxt;
   reg aleOut_r;
   reg aleOut_nxt;
   reg aleOe_r;
   reg aleOe_nxt;
   reg prgStbN_r;
   reg prgStbN_nxt;
   wire blkRst;
   wire selN;
   wire extExec;
   wire extFetch;
   wire aleAllowed;

   // every pin passes three stages; only the filtered level is used
   always @(posedge core_clk) begin
      if (!rst_n) begin
         syncS1_r <= `SYNC_RST;
         syncS2_r <= `SYNC_RST;
         syncS3_r <= `SYNC_RST;
         syncFilt_r <= `SYNC_RST;
      end else begin
         syncS1_r <= {resetPin, extAccessSelN, lowPortIn};
         syncS2_r <= syncS1_r;
         syncS3_r <= syncS2_r;
         syncFilt_r <= agree(syncS2_r, syncS3_r, syncFilt_r);
      end
   end

   // reset pin must stay high for two full machine cycles
   always @(posedge core_clk) begin
      if (!rst_n) begin
         rstCnt_r <= {`RST_CNT_W{1'b0}};
         devRst_r <= 1'b0;
      end else if (!syncFilt_r[9]) begin
         rstCnt_r <= {`RST_CNT_W{1'b0}};
         devRst_r <= 1'b0;
      end else if (rstCnt_r == RST_CYC - 1'b1) begin
         devRst_r <= 1'b1; // R20
      end else begin
         rstCnt_r <= rstCnt_r + 1'b1;
      end
   end

   assign blkRst = !rst_n || devRst_r;

   // strap is caught once stages two and three both hold the real pin level,
   // otherwise the reset value of the chain would be latched instead
   always @(posedge core_clk) begin
      if (blkRst) begin
         settle_r <= `SEL_SETTLE;
         selLatched_r <= 1'b1;
      end else if (settle_r != 3'h0) begin
         settle_r <= settle_r - 3'h1;
         if (settle_r == 3'h1) begin
            selLatched_r <= syncFilt_r[8]; // R18
         end
      end
   end

   // with the fuse blank the strap is followed live
   assign selN = lockBit1 ? selLatched_r : syncFilt_r[8]; // R18
   assign extExec = !selN; // R16 R17
   assign extFetch = extExec || (fetchReq && (fetchAddr > `INT_CODE_TOP)); // R16
   assign aleAllowed = !aleDisable || extExec || codeMoveActive; // R11 R12

   // half-cycle sequencer; requests are taken at the last window of a half
   always @* begin
      ph_nxt = (ph_r == `PH_LAST) ? 3'h0 : ph_r + 3'h1;
      halfB_nxt = halfB_r;
      kind_nxt = kind_r;
      wr_nxt = wr_r;
      wide_nxt = wide_r;
      addr_nxt = addr_r;
      wdat_nxt = wdat_r;
      fReq_nxt = fReq_r;
      if (ph_r == `PH_LAST) begin
         halfB_nxt = !halfB_r;
         fReq_nxt = 1'b0;
         case (kind_r)
            `K_DATA_A: begin
               kind_nxt = `K_DATA_B; // R10 R15
            end
            default: begin
               // data accesses start a machine cycle and never follow back to back
               if (halfB_r && xdataReq && kind_r != `K_DATA_B) begin
                  kind_nxt = `K_DATA_A;
                  wr_nxt = xdataWrite;
                  wide_nxt = xdataWide;
                  addr_nxt = xdataAddr;
                  wdat_nxt = xdataWrData;
               end else if (extFetch) begin
                  kind_nxt = `K_FETCH; // R14
                  addr_nxt = fetchAddr;
                  fReq_nxt = fetchReq;
               end else begin
                  kind_nxt = `K_IDLE;
               end
            end
         endcase
      end
   end

   // pin levels for the coming cycle, worked out from the next state
   always @* begin
      aleOe_nxt = 1'b1;
      aleOut_nxt = (ph_nxt <= `ALE_LAST_PH) && (kind_nxt != `K_DATA_B); // R9 R10
      // gate changes only between halves so no pulse is ever cut short
      if ((ph_nxt == 3'h0) ? !aleAllowed : !aleOe_r) begin
         aleOe_nxt = 1'b0; // R11
         aleOut_nxt = 1'b0;
      end
      prgStbN_nxt = !((kind_nxt == `K_FETCH) && (ph_nxt >= `STB_FIRST_PH)); // R13 R22
      lpOut_nxt = lowPortLatch;
      lpOe_nxt = quasiOe(lowPortLatch); // R6
      hpOut_nxt = highPortLatch;
      hpOe_nxt = quasiOe(highPortLatch);
      hpWeak_nxt = highPortLatch; // R5 R7
      a3Out_nxt = aux3Latch;
      case (kind_nxt)
         `K_FETCH, `K_DATA_A: begin
            // address until just after the latch strobe falls, then float
            lpOut_nxt = addr_nxt[7:0]; // R1 R21
            lpOe_nxt = (ph_nxt <= `ADDR_LAST_PH) ? 8'hff : 8'h00; // R2 R21
         end
         `K_DATA_B: begin
            lpOut_nxt = wdat_nxt; // R1
            lpOe_nxt = wr_nxt ? 8'hff : 8'h00; // R2 R21
            if (ph_nxt >= `STB_FIRST_PH) begin
               a3Out_nxt = aux3Latch & (wr_nxt ? 8'hbf : 8'h7f); // R19 R22
            end
         end
         default: begin
            lpOut_nxt = lowPortLatch;
         end
      endcase
      if (kind_nxt == `K_FETCH || (kind_nxt[3:2] != 2'h0 && wide_nxt)) begin
         hpOut_nxt = addr_nxt[15:8]; // R3
         hpOe_nxt = 8'hff; // R4
         hpWeak_nxt = 8'h00;
      end
   end

   // sequencer state
   always @(posedge core_clk) begin
      if (blkRst) begin
         ph_r <= 3'h0;
         halfB_r <= 1'b0;
         kind_r <= `K_IDLE;
         wr_r <= 1'b0;
         wide_r <= 1'b0;
         addr_r <= 16'h0000;
         wdat_r <= 8'h00;
         fReq_r <= 1'b0;
      end else begin
         ph_r <= ph_nxt;
         halfB_r <= halfB_nxt;
         kind_r <= kind_nxt;
         wr_r <= wr_nxt;
         wide_r <= wide_nxt;
         addr_r <= addr_nxt;
         wdat_r <= wdat_nxt;
         fReq_r <= fReq_nxt;
      end
   end

   // read data is taken three edges after the strobe window closes,
   // the time the pin needs to clear the sync chain
   always @(posedge core_clk) begin
      if (blkRst) begin
         fPend_r <= 1'b0;
         dPend_r <= 1'b0;
         fData_r <= 8'h00;
         dData_r <= 8'h00;
         fDone_r <= 1'b0;
         dDone_r <= 1'b0;
      end else begin
         fDone_r <= 1'b0;
         dDone_r <= 1'b0;
         if (ph_r == `PH_LAST) begin
            fPend_r <= (kind_r == `K_FETCH) && fReq_r;
            dPend_r <= (kind_r == `K_DATA_B) && !wr_r;
            dDone_r <= (kind_r == `K_DATA_B) && wr_r;
         end else if (ph_r == `CAP_PH) begin
            if (fPend_r) begin
               fData_r <= syncFilt_r[7:0];
               fDone_r <= 1'b1;
            end
            if (dPend_r) begin
               dData_r <= syncFilt_r[7:0];
               dDone_r <= 1'b1;
            end
            fPend_r <= 1'b0;
            dPend_r <= 1'b0;
         end
      end
   end

   // pin registers; ports idle as quasi-bidirectional at reset
   always @(posedge core_clk) begin
      if (blkRst) begin
         lpOut_r <= `PORT_RST;
         lpOe_r <= 8'h00;
         hpOut_r <= `PORT_RST;
         hpOe_r <= 8'h00;
         hpWeak_r <= `PORT_RST;
         a1Out_r <= `PORT_RST;
         a3Out_r <= `PORT_RST;
         aleOut_r <= 1'b0;
         aleOe_r <= 1'b0;
         prgStbN_r <= 1'b1;
      end else begin
         lpOut_r <= lpOut_nxt;
         lpOe_r <= lpOe_nxt;
         hpOut_r <= hpOut_nxt;
         hpOe_r <= hpOe_nxt;
         hpWeak_r <= hpWeak_nxt;
         a1Out_r <= aux1Latch; // R7
         a3Out_r <= a3Out_nxt;
         aleOut_r <= aleOut_nxt; // R8
         aleOe_r <= aleOe_nxt;
         prgStbN_r <= prgStbN_nxt;
      end
   end

   // core-side results
   assign coreReset = devRst_r;
   assign fetchData = fData_r;
   assign fetchDone = fDone_r;
   assign xdataRdData = dData_r;
   assign xdataDone = dDone_r;
   assign lowPortValue = syncFilt_r[7:0];

   // low and high port pins
   assign lowPortOut = lpOut_r;
   assign lowPortOe = lpOe_r;
   assign highPortOut = hpOut_r;
   assign highPortOe = hpOe_r;
   assign highPortWeak = hpWeak_r;

   // plain ports: a one is only a weak pull, so outside logic may win
   assign aux1Out = a1Out_r;
   assign aux1Oe = quasiOe(a1Out_r); // R7
   assign aux1Weak = a1Out_r;
   assign aux3Out = a3Out_r;
   assign aux3Oe = quasiOe(a3Out_r); // R7
   assign aux3Weak = a3Out_r;

   // strobe pins; the weak pull holds the latch strobe high while it is gated off
   assign aleOut = aleOut_r;
   assign aleOe = aleOe_r;
   assign aleWeak = !aleOe_r;
   assign prgReadStrobeN = prgStbN_r;

endmodule // ext_mem_bus

// >>> verif/ext_mem_bus_assertions.sv
`timescale 1ns/1ps
module ext_mem_bus_checker (
   // clock and resets
   input wire core_clk,
   input wire rst_n,
   input wire coreReset,
   // strobes and completions
   input wire aleOut,
   input wire aleOe,
   input wire aleDisable,
   input wire prgReadStrobeN,
   input wire fetchDone,
   input wire xdataDone,
   // bus ports
   input wire [7:0] aux3Out,
   input wire [7:0] lowPortOut,
   input wire [7:0] lowPortOe,
   input wire [7:0] highPortOut,
   input wire [7:0] highPortOe
);
   // weak high is not a pulse, so only a driven high counts
   wire aleDrv = aleOe & aleOut;
   wire dataStb = !(aux3Out[7] & aux3Out[6]);
   default clocking @(posedge core_clk); endclocking
   default disable iff (!rst_n || coreReset);
   // strobe shapes
   sequence aleHigh; aleDrv[*2] ##1 !aleDrv; endsequence
   sequence skipHalf; !aleDrv ##3 dataStb; endsequence
   sequence lowThree(s); (!s)[*3] ##1 s; endsequence
   ale_width_a: assert property ($rose(aleDrv) |-> aleHigh)
      else $error("ale width");
   ale_rate_a: assert property ($rose(aleDrv) ##0 (!aleDisable)[*7] |->
      aleDrv or skipHalf) else $error("ale rate");
   prg_width_a: assert property ($fell(prgReadStrobeN) |-> lowThree(prgReadStrobeN))
      else $error("prg width");
   addr_valid_a: assert property ($fell(prgReadStrobeN) |->
      lowPortOe == 8'h00 && $past(aleDrv, 2) && !$past(aleDrv) && $past(lowPortOe) == 8'hff)
      else $error("addr phase");
   high_strong_a: assert property (!prgReadStrobeN |->
      (highPortOe & highPortOut) == highPortOut) else $error("high ones weak");
   rd_strobe_a: assert property ($fell(aux3Out[7]) |->
      lowThree(aux3Out[7]) and (lowPortOe == 8'h00 && prgReadStrobeN)[*3])
      else $error("read strobe");
   wr_strobe_a: assert property ($fell(aux3Out[6]) |->
      lowThree(aux3Out[6]) and (lowPortOe == 8'hff && prgReadStrobeN)[*3])
      else $error("write strobe");
   fetch_done_a: assert property (fetchDone |->
      !$past(prgReadStrobeN, 4) && $past(prgReadStrobeN, 3) ##1 !fetchDone)
      else $error("fetch done");
   data_done_a: assert property (xdataDone |->
      !$past(aux3Out[7], 4) || !$past(aux3Out[6])) else $error("data done");
endmodule // ext_mem_bus_checker

bind ext_mem_bus ext_mem_bus_checker chk (.*);

// >>> verif/ext_mem_model.sv
`timescale 1ns/1ps
module ext_mem_model (
   // clock
   input wire core_clk,
   // strobes from the device
   input wire aleOut,
   input wire aleOe,
   input wire prgReadStrobeN,
   input wire [7:0] aux3Out,
   // address and data pins
   input wire [7:0] highPortOut,
   input wire [7:0] lowPortOut,
   input wire [7:0] lowPortOe,
   output wire [7:0] lowPortIn
);
   reg [7:0] addrLo_r = 8'h00;
   reg [7:0] bus_r = 8'h00;
   reg [7:0] dmem [0:65535];
   wire [15:0] addr = {highPortOut, addrLo_r};
   // code byte is a hash of its address, data comes from the array
   wire [7:0] memDrv = prgReadStrobeN ? dmem[addr] : addr[7:0] ^ addr[15:8] ^ 8'h5a;
   // released bus never keeps its last value
   wire [7:0] ext = (prgReadStrobeN & aux3Out[7]) ? ~bus_r : memDrv;
   assign lowPortIn = (lowPortOe & lowPortOut) | (~lowPortOe & ext);
   // outside latch is transparent while the strobe is high
   always @(posedge core_clk) begin
      bus_r <= lowPortIn;
      if (aleOe & aleOut)
         addrLo_r <= lowPortOut;
      if (!aux3Out[6])
         dmem[addr] <= lowPortOut;
   end
endmodule // ext_mem_model

// >>> verif/testbench.sv
`timescale 1ns/1ps
module testbench;
   logic core_clk = 1'h0, rst_n = 1'h0, resetPin = 1'h0, extAccessSelN = 1'h0, lockBit1 = 1'h0;
   logic fetchReq = 1'h0, xdataReq = 1'h0, xdataWrite = 1'h0, xdataWide = 1'h0;
   logic aleDisable = 1'h0, codeMoveActive = 1'h0, alePrev = 1'h0, psenPrev = 1'h1;
   logic [15:0] fetchAddr = 16'h0, xdataAddr = 16'h0, aleRises = 16'h0, psenLows = 16'h0;
   logic [7:0] xdataWrData = 8'h0, lowPortLatch = 8'hff, highPortLatch = 8'hff;
   logic [7:0] aux1Latch = 8'hff, aux3Latch = 8'hff;
   int fails = 0, compares = 0, cyc = 0;
   wire coreReset, fetchDone, xdataDone, aleOut, aleOe, aleWeak, prgReadStrobeN;
   wire [7:0] fetchData, xdataRdData, lowPortIn, lowPortOut, lowPortOe, lowPortValue;
   wire [7:0] highPortOut, highPortOe, highPortWeak, aux1Out, aux1Oe, aux1Weak;
   wire [7:0] aux3Out, aux3Oe, aux3Weak;
   ext_mem_bus dut (.*);
   ext_mem_model mem (.*);
   task check(input logic [31:0] seen, input logic [31:0] exp);
      compares++;
      if (seen !== exp) begin
         fails++;
         $display("wrong value at %0t: %h vs %h", $time, seen, exp);
      end
   endtask
   task conclude;
      if (fails == 0 && compares > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask
   // bounded wait for a one-cycle done
   task waitOn(input int which);
      @(negedge core_clk);
      for (int i = 0; i < 60 && (which ? xdataDone : fetchDone) !== 1'h1; i++)
         @(negedge core_clk);
   endtask
   // third done is surely from the new address
   task fetch(input logic [15:0] a);
      @(posedge core_clk);
      fetchAddr <= a;
      repeat (3) waitOn(0);
      check({fetchDone, fetchData}, {1'h1, a[7:0] ^ a[15:8] ^ 8'h5a});
      for (int i = 0; i < 8 && prgReadStrobeN !== 1'h0; i++)
         @(negedge core_clk);
      check(highPortOut, a[15:8]);
   endtask
   task xacc(input logic wr, input logic wide, input logic [15:0] a, input logic [7:0] d);
      @(posedge core_clk);
      {xdataReq, xdataWrite, xdataWide, xdataAddr, xdataWrData} <= {1'h1, wr, wide, a, d};
      @(negedge core_clk);
      for (int i = 0; i < 60 && (aux3Out[7] & aux3Out[6]) !== 1'h0; i++)
         @(negedge core_clk);
      check(highPortOut, wide ? a[15:8] : highPortLatch);
      waitOn(1);
      check({xdataDone, wr ? d : xdataRdData}, {1'h1, d});
      @(posedge core_clk);
      xdataReq <= 1'h0;
   endtask
   initial forever #2 core_clk = ~core_clk;
   // hang limit
   always @(posedge core_clk) begin
      cyc <= cyc + 1;
      if (cyc == 6000) begin
         fails++;
         conclude;
      end
   end
   // strobe edge counters
   always @(negedge core_clk) begin
      alePrev <= aleOe & aleOut;
      psenPrev <= prgReadStrobeN;
      if ((aleOe & aleOut & ~alePrev) === 1'h1)
         aleRises++;
      if ((psenPrev & ~prgReadStrobeN) === 1'h1)
         psenLows++;
   end
   initial begin
      logic [15:0] a;
      logic [7:0] d;
      void'($urandom(51116));
      repeat (20) @(posedge core_clk);
      rst_n <= 1'h1;
      fetchReq <= 1'h1;
      lowPortLatch <= 8'($urandom);
      highPortLatch <= 8'($urandom);
      aux1Latch <= 8'($urandom);
      aux3Latch <= {2'h3, 6'($urandom)};
      fetch(16'h0000);
      fetch(16'hffff);
      repeat (4) fetch(16'($urandom));
      check({aux1Oe, aux1Weak, aux3Weak}, {~aux1Latch, aux1Latch, aux3Latch});
      // back-to-back write and read, both pointer kinds
      for (int i = 0; i < 4; i++) begin
         a = 16'($urandom);
         d = 8'($urandom);
         xacc(1'h1, i[0], a, d);
         xacc(1'h0, i[0], a, d);
      end
      aleRises = 16'h0;
      repeat (60) @(posedge core_clk);
      check(aleRises, 16'ha);
      extAccessSelN <= 1'h1;
      fetch(16'h2000);
      @(posedge core_clk);
      aleDisable <= 1'h1;
      fetchAddr <= 16'h0100;
      repeat (12) @(posedge core_clk);
      {aleRises, psenLows} = 32'h0;
      repeat (36) @(negedge core_clk);
      check(psenLows, 16'h0);
      check({aleRises, aleOe, aleWeak}, 18'h1);
      check(lowPortOe & lowPortLatch, 8'h0);
      check({highPortOe, highPortWeak}, {~highPortLatch, highPortLatch});
      @(posedge core_clk);
      codeMoveActive <= 1'h1;
      repeat (24) @(posedge core_clk);
      check(aleRises != 16'h0, 1'h1);
      codeMoveActive <= 1'h0;
      extAccessSelN <= 1'h0;
      repeat (12) @(posedge core_clk);
      aleRises = 16'h0;
      repeat (36) @(posedge core_clk);
      check(aleRises, 16'h6);
      // strap caught at reset when locked
      aleDisable <= 1'h0;
      lockBit1 <= 1'h1;
      rst_n <= 1'h0;
      repeat (4) @(posedge core_clk);
      rst_n <= 1'h1;
      repeat (8) @(posedge core_clk);
      extAccessSelN <= 1'h1;
      fetch(16'h0100);
      @(posedge core_clk);
      resetPin <= 1'h1;
      repeat (10) @(negedge core_clk);
      check(coreReset, 1'h0);
      repeat (30) @(negedge core_clk);
      check(coreReset, 1'h1);
      @(posedge core_clk);
      resetPin <= 1'h0;
      repeat (10) @(negedge core_clk);
      check(coreReset, 1'h0);
      conclude;
   end
endmodule // testbench
